// ===== hdl/gsb_pkg.sv
/*
 * Constants, field layouts and carrier structs for the gigabit status and
 * bypass register bank.
 * Assumes a management register port of 5-bit address and 16-bit data.
 */
// Overview of operation
// - Status bits 12 and 15 follow gigabit link and descrambler lock, reset 0.
// - Status bit 14 latches a descrambler lock error until self-cleared.
// - Status bit 13 latches a gigabit link disconnect, self-clearing.
// - Status bits 11 and 10 latch receive and transmit errors, self-clearing.
// - Status bit 9 latches a stream start delimiter error, self-clearing.
// - Status bit 8 latches a stream end delimiter error, self-clearing.
// - Status bit 7 latches a carrier extension error, self-clearing.
// - Status bits 6 and 5 show noncompliant partner and crossover error.
// - Status bits 4:0 are reserved, read-only zero.
// - Bypass bit 15 disables the line transmitter, read-write, reset 0.
// - Bypass bits 14..12 bypass 4B/5B coder, scrambler, descrambler.
// - Bypass bits 11 and 10 bypass PCS receive and transmit paths.
// - Bypass bit 9 bypasses the link fail hold timer; bits 8, 0 reserved.
// - Sticky bit 7 resets 1, disables crossover correction at forced 10/100.
// - Sticky bit 6 resets 0, disables noncompliant partner detection.
// - Sticky bit 5 resets 0, disables automatic pair swap correction.
// - Sticky bit 4 resets 0, disables per-subchannel polarity correction.
// - Sticky bit 3 resets 1; 1 honours, 0 ignores advertised ability.
// - Bypass bit 2 disables the transmit pulse shaping filter, reset 0.
// - Sticky bit 1 stops automatic gigabit next page exchange.
// - Counters at 19 and 20 are 8 bits, saturate at 255, clear on read.
// - The false carrier counter counts separately from receive errors.
// - Sticky bits survive software reset only while sticky enable is set.
package gsb_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;

    // Register addresses.
    localparam logic [4:0] ADDR_STATUS = 5'h11;
    localparam logic [4:0] ADDR_BYPASS = 5'h12;
    localparam logic [4:0] ADDR_RXERR_CNT = 5'h13;
    localparam logic [4:0] ADDR_FCAR_CNT = 5'h14;

    // Status register bit positions.
    localparam int ST_DESCR_LOCK = 15;
    localparam int ST_LOCK_ERR = 14;
    localparam int ST_DISCONNECT = 13;
    localparam int ST_LINK_UP = 12;
    localparam int ST_RX_ERR = 11;
    localparam int ST_TX_ERR = 10;
    localparam int ST_SSD_ERR = 9;
    localparam int ST_ESD_ERR = 8;
    localparam int ST_CEXT_ERR = 7;
    localparam int ST_NONCOMP = 6;
    localparam int ST_XOVER_ERR = 5;

    // Bypass register bit positions.
    localparam int BP_TX_DIS = 15;
    localparam int BP_4B5B = 14;
    localparam int BP_SCR = 13;
    localparam int BP_DESCR = 12;
    localparam int BP_PCS_RX = 11;
    localparam int BP_PCS_TX = 10;
    localparam int BP_LFHT = 9;
    localparam int BP_XOVER_DIS = 7;
    localparam int BP_NONCOMP_DIS = 6;
    localparam int BP_PAIRSWAP_DIS = 5;
    localparam int BP_POL_DIS = 4;
    localparam int BP_PARDET_ADV = 3;
    localparam int BP_PULSE_DIS = 2;
    localparam int BP_NP_DIS = 1;

    // Writable bits of the bypass register and which of them are sticky.
    localparam logic [15:0] BP_WR_MASK = 16'hfefe;
    localparam logic [15:0] BP_STICKY_MASK = 16'h00fa;
    localparam logic [15:0] BP_RESET = 16'h0088;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;

    // Event strobes from the gigabit line functions, one cycle each.
    typedef struct packed {
        logic lock_err;
        logic disconnect;
        logic rx_err;
        logic tx_err;
        logic stream_start_delimiter_err;
        logic stream_end_delimiter_err;
        logic cext_err;
    } gsb_events_s;

    // Level status from the gigabit line functions.
    typedef struct packed {
        logic descr_lock;
        logic link_up;
        logic noncompliant_gigabit_partner;
        logic xover_err;
    } gsb_levels_s;

    // Controls handed to the line functions.
    typedef struct packed {
        logic tx_disable;
        logic bypass_4b5b;
        logic bypass_scrambler;
        logic bypass_descrambler;
        logic bypass_pcs_rx;
        logic bypass_pcs_tx;
        logic bypass_link_fail_hold_timer;
        logic automatic_crossover_correction_dis_forced;
        logic noncompliant_gigabit_partner_detect_dis;
        logic pair_swap_correction_dis;
        logic polarity_correction_dis;
        logic parallel_detect_honour_adv;
        logic pulse_shaping_dis;
        logic next_page_auto_dis;
    } gsb_ctrl_s;

endpackage

// ===== hdl/gsb_sat_cnt.sv
/*
 * Saturating event counter that clears when read.
 * Assumes a one-cycle increment strobe and a one-cycle read strobe.
 */
`timescale 1ns/1ps
module gsb_sat_cnt #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic rd_clr,
    output logic [WIDTH-1:0] count
);
    import gsb_pkg::*;

    // ========================================================================
    // Elaboration check
    initial begin
        if (WIDTH < 2 || WIDTH > 15) begin
            $error("Counter width out of range.");
        end
    end

    localparam logic [WIDTH-1:0] MAX = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
    localparam logic [WIDTH-1:0] ZERO = '0;

    // ========================================================================
    // Counter
    // A read clears the count, but an event in the same cycle counts as one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= ZERO;
        end else if (rd_clr) begin
            count <= inc ? ONE : ZERO;
        end else if (inc && count != MAX) begin
            count <= count + ONE;
        end
    end

    a_cnt_saturates: assert property (@(posedge clk) disable iff (!rst_n)
        (count == MAX && !rd_clr) |=> count == MAX)
        else $error("Counter left saturation without a read.");
    a_cnt_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_clr && !inc) |=> count == ZERO)
        else $error("Counter not cleared by read.");
    a_cnt_steps_one: assert property (@(posedge clk) disable iff (!rst_n)
        (inc && !rd_clr && count != MAX) |=> count == $past(count) + ONE)
        else $error("Counter did not step by one.");
    c_cnt_saturated: cover property (@(posedge clk) disable iff (!rst_n) count == MAX);
endmodule

// ===== hdl/gsb_sc_flag.sv
/*
 * Self-clearing sticky status flag.
 * Assumes a one-cycle event strobe and a one-cycle register read strobe.
 */
`timescale 1ns/1ps
module gsb_sc_flag (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic event_in,
    input wire logic rd_clr,
    output logic flag
);
    // ========================================================================
    // Flag
    // Set wins over the read clear so a coincident event is kept.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (event_in) begin
            flag <= 1'b1;
        end else if (rd_clr) begin
            flag <= 1'b0;
        end
    end

    a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        event_in |=> flag)
        else $error("Flag missed an event.");
    a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (flag && !rd_clr) |=> flag)
        else $error("Flag dropped without a read.");
endmodule

// ===== hdl/gsb_regs.sv
/*
 * Gigabit status extension, bypass control and two error counters as seen
 * over the management register port of the transceiver.
 * Assumes a serial management front end that presents one-cycle read and
 * write strobes with a 5-bit register address, and line functions that give
 * one-cycle event strobes synchronous to CLK.
 */
`timescale 1ns/1ps
module gsb_regs (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SOFT_RST,
    input wire logic STICKY_RST_EN,
    input wire logic RD_EN,
    input wire logic WR_EN,
    input wire logic [gsb_pkg::ADDR_W-1:0] ADDR,
    input wire logic [gsb_pkg::DATA_W-1:0] WDATA,
    output logic [gsb_pkg::DATA_W-1:0] RDATA,
    input wire gsb_pkg::gsb_events_s EVENTS,
    input wire gsb_pkg::gsb_levels_s LEVELS,
    input wire logic RX_ERR_EVT,
    input wire logic FALSE_CARRIER_EVT,
    output gsb_pkg::gsb_ctrl_s CTRL
);
    import gsb_pkg::*;

    // ========================================================================
    // Reset synchroniser
    logic rst_meta_q;
    logic rst_n;

    // Release of the asynchronous reset passes two flip-flops.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ========================================================================
    // Access decode
    logic rd_status;
    logic rd_rxcnt;
    logic rd_fccnt;
    logic wr_bypass;

    // Reads of the status and counter words drive their clear-on-read logic.
    assign rd_status = RD_EN && ADDR == ADDR_STATUS;
    assign rd_rxcnt = RD_EN && ADDR == ADDR_RXERR_CNT;
    assign rd_fccnt = RD_EN && ADDR == ADDR_FCAR_CNT;
    assign wr_bypass = WR_EN && ADDR == ADDR_BYPASS;

    // ========================================================================
    // Self-clearing status flags
    localparam int N_FLAGS = 7;
    logic [N_FLAGS-1:0] flag_evt;
    logic [N_FLAGS-1:0] flag_q;

    // Event order matches status bits 14 down to 7 without link status.
    assign flag_evt = {EVENTS.lock_err, EVENTS.disconnect, EVENTS.rx_err, EVENTS.tx_err,
                       EVENTS.stream_start_delimiter_err, EVENTS.stream_end_delimiter_err,
                       EVENTS.cext_err};

    // One flag per event, each cleared by a status read.
    genvar gi;
    generate
        for (gi = 0; gi < N_FLAGS; gi++) begin : g_flag
            gsb_sc_flag u_flag (
                .clk(CLK),
                .rst_n(rst_n),
                .event_in(flag_evt[gi]),
                .rd_clr(rd_status),
                .flag(flag_q[gi])
            );
        end
    endgenerate

    // ========================================================================
    // Level status
    // The bypass register is declared here because the partner mask reads it.
    logic [DATA_W-1:0] bypass_q;
    logic [DATA_W-1:0] bypass_d;
    logic lock_q;
    logic link_q;
    logic noncomp_q;
    logic xover_q;

    // Live status sampled each cycle; partner detection masked when disabled.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
            link_q <= 1'b0;
            noncomp_q <= 1'b0;
            xover_q <= 1'b0;
        end else begin
            lock_q <= LEVELS.descr_lock;
            link_q <= LEVELS.link_up;
            noncomp_q <= LEVELS.noncompliant_gigabit_partner
                         && !bypass_q[BP_NONCOMP_DIS];
            xover_q <= LEVELS.xover_err;
        end
    end

    logic [DATA_W-1:0] status_word;

    // Status word assembly; bits 4:0 read zero.
    always_comb begin
        status_word = '0;
        status_word[ST_DESCR_LOCK] = lock_q;
        status_word[ST_LOCK_ERR] = flag_q[6];
        status_word[ST_DISCONNECT] = flag_q[5];
        status_word[ST_LINK_UP] = link_q;
        status_word[ST_RX_ERR] = flag_q[4];
        status_word[ST_TX_ERR] = flag_q[3];
        status_word[ST_SSD_ERR] = flag_q[2];
        status_word[ST_ESD_ERR] = flag_q[1];
        status_word[ST_CEXT_ERR] = flag_q[0];
        status_word[ST_NONCOMP] = noncomp_q;
        status_word[ST_XOVER_ERR] = xover_q;
    end

    // ========================================================================
    // Bypass control register
    // Software reset restores plain bits always, sticky bits only when the
    // sticky enable is clear; a write in the same cycle is ignored.
    always_comb begin
        bypass_d = bypass_q;
        if (SOFT_RST) begin
            if (STICKY_RST_EN) begin
                bypass_d = (bypass_q & BP_STICKY_MASK)
                           | (BP_RESET & ~BP_STICKY_MASK);
            end else begin
                bypass_d = BP_RESET;
            end
        end else if (wr_bypass) begin
            bypass_d = WDATA & BP_WR_MASK;
        end
    end

    // Bypass register state.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            bypass_q <= BP_RESET;
        end else begin
            bypass_q <= bypass_d;
        end
    end

    // Controls to the line functions come straight from the register.
    always_comb begin
        CTRL.tx_disable = bypass_q[BP_TX_DIS];
        CTRL.bypass_4b5b = bypass_q[BP_4B5B];
        CTRL.bypass_scrambler = bypass_q[BP_SCR];
        CTRL.bypass_descrambler = bypass_q[BP_DESCR];
        CTRL.bypass_pcs_rx = bypass_q[BP_PCS_RX];
        CTRL.bypass_pcs_tx = bypass_q[BP_PCS_TX];
        CTRL.bypass_link_fail_hold_timer = bypass_q[BP_LFHT];
        CTRL.automatic_crossover_correction_dis_forced = bypass_q[BP_XOVER_DIS];
        CTRL.noncompliant_gigabit_partner_detect_dis = bypass_q[BP_NONCOMP_DIS];
        CTRL.pair_swap_correction_dis = bypass_q[BP_PAIRSWAP_DIS];
        CTRL.polarity_correction_dis = bypass_q[BP_POL_DIS];
        CTRL.parallel_detect_honour_adv = bypass_q[BP_PARDET_ADV];
        CTRL.pulse_shaping_dis = bypass_q[BP_PULSE_DIS];
        CTRL.next_page_auto_dis = bypass_q[BP_NP_DIS];
    end

    // ========================================================================
    // Error counters
    logic [CNT_W-1:0] rxcnt;
    logic [CNT_W-1:0] fccnt;

    // Receive error counter.
    gsb_sat_cnt #(.WIDTH(CNT_W)) u_rxcnt (
        .clk(CLK),
        .rst_n(rst_n),
        .inc(RX_ERR_EVT),
        .rd_clr(rd_rxcnt),
        .count(rxcnt)
    );

    // False carrier counter, fed apart from the receive error counter.
    gsb_sat_cnt #(.WIDTH(CNT_W)) u_fccnt (
        .clk(CLK),
        .rst_n(rst_n),
        .inc(FALSE_CARRIER_EVT),
        .rd_clr(rd_fccnt),
        .count(fccnt)
    );

    // ========================================================================
    // Read data
    logic [DATA_W-1:0] rdata_d;

    // Read mux; unmapped addresses and reserved bits read zero.
    always_comb begin
        rdata_d = '0;
        unique case (ADDR)
            ADDR_STATUS: rdata_d = status_word;
            ADDR_BYPASS: rdata_d = bypass_q & BP_WR_MASK;
            ADDR_RXERR_CNT: rdata_d = {{(DATA_W-CNT_W){1'b0}}, rxcnt};
            ADDR_FCAR_CNT: rdata_d = {{(DATA_W-CNT_W){1'b0}}, fccnt};
            default: rdata_d = '0;
        endcase
    end

    // Read data is captured on the read strobe and held until the next read.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= '0;
        end else if (RD_EN) begin
            RDATA <= rdata_d;
        end
    end

    // ========================================================================
    // Checks
    a_status_rd_clear: assert property (@(posedge CLK) disable iff (!rst_n)
        (rd_status && !EVENTS.rx_err) |=> !flag_q[4])
        else $error("Receive error flag survived a read.");
    a_event_kept: assert property (@(posedge CLK) disable iff (!rst_n)
        (rd_status && flag_evt != '0) |=> (flag_q & $past(flag_evt)) == $past(flag_evt))
        else $error("Event lost on coincident read.");
    a_link_follows: assert property (@(posedge CLK) disable iff (!rst_n)
        RD_EN && ADDR == ADDR_STATUS |=> RDATA[ST_LINK_UP] == $past(link_q))
        else $error("Link status not shown.");
    a_reserved_zero: assert property (@(posedge CLK) disable iff (!rst_n)
        $past(RD_EN) && $past(ADDR) == ADDR_STATUS |-> RDATA[4:0] == 5'h00)
        else $error("Reserved status bits nonzero.");
    a_bypass_write: assert property (@(posedge CLK) disable iff (!rst_n)
        (wr_bypass && !SOFT_RST) |=> bypass_q == ($past(WDATA) & BP_WR_MASK))
        else $error("Bypass write not stored.");
    a_sticky_keep: assert property (@(posedge CLK) disable iff (!rst_n)
        (SOFT_RST && STICKY_RST_EN) |=>
        (bypass_q & BP_STICKY_MASK) == ($past(bypass_q) & BP_STICKY_MASK))
        else $error("Sticky bits lost on software reset.");
    a_sticky_default: assert property (@(posedge CLK) disable iff (!rst_n)
        (SOFT_RST && !STICKY_RST_EN) |=> bypass_q == BP_RESET)
        else $error("Defaults not restored on software reset.");
    a_txdis_drive: assert property (@(posedge CLK) disable iff (!rst_n)
        CTRL.tx_disable == bypass_q[BP_TX_DIS] && !bypass_q[8] && !bypass_q[0])
        else $error("Transmit disable or reserved bit wrong.");
    a_noncomp_mask: assert property (@(posedge CLK) disable iff (!rst_n)
        bypass_q[BP_NONCOMP_DIS] && $past(bypass_q[BP_NONCOMP_DIS]) |-> !noncomp_q)
        else $error("Partner detect not disabled.");
    c_status_read: cover property (@(posedge CLK) disable iff (!rst_n)
        rd_status && flag_q != '0);
    c_soft_keep: cover property (@(posedge CLK) disable iff (!rst_n)
        SOFT_RST && STICKY_RST_EN && bypass_q != BP_RESET);
    c_fc_read: cover property (@(posedge CLK) disable iff (!rst_n)
        rd_fccnt && fccnt != CNT_RESET);
endmodule

// ===== sim/gsb_host_model.sv
/*
 * Behavioural management host that reaches the register bank through its
 * one-cycle read and write strobes.
 * Assumes the bank samples strobes on the rising edge and loads RDATA there.
 */
`timescale 1ns/1ps
module gsb_host_model (
    input wire logic clk,
    output logic rd_en,
    output logic wr_en,
    output logic [4:0] addr,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    // =========================================================
    // Idle levels
    // Strobes start low so no access is seen while reset is applied.
    initial begin
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 5'h00;
        wdata = 16'h0000;
    end

    // =========================================================
    // Register cycles
    // A write holds address and data over one rising edge, then releases them
    // to an inverted pattern so stale values cannot pass for held ones.
    // The host forces its chosen configuration through these writes.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask

    // A read holds the address over one rising edge and takes the
    // registered answer half a cycle later, once it has settled.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        addr = ~a;
        d = rdata;
    endtask
endmodule

// ===== sim/gsb_regs_tb.sv
/*
 * Self-checking testbench for the status, bypass and counter register bank.
 * Assumes the host model drives the register port; events and levels are
 * driven here on the falling edge of the clock.
 */
`timescale 1ns/1ps
module gsb_regs_tb;
    import gsb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_rst = 1'b0;
    logic sticky_en = 1'b0;
    logic rx_evt = 1'b0;
    logic fc_evt = 1'b0;
    logic rd_en;
    logic wr_en;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] got;
    gsb_events_s events = '0;
    gsb_levels_s levels = '0;
    gsb_ctrl_s ctrl;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int ev_bit [7] = '{7, 8, 9, 10, 11, 13, 14};

    // =========================================================
    // Clock, instances and watchdog
    // The clock toggles every 12.5 ns, a period of 25 ns.
    always #12.5 clk = ~clk;

    gsb_regs gsb_regs_inst (.CLK(clk), .RSTN(rst_n), .SOFT_RST(soft_rst),
        .STICKY_RST_EN(sticky_en), .RD_EN(rd_en), .WR_EN(wr_en), .ADDR(addr),
        .WDATA(wdata), .RDATA(rdata), .EVENTS(events), .LEVELS(levels),
        .RX_ERR_EVT(rx_evt), .FALSE_CARRIER_EVT(fc_evt), .CTRL(ctrl));

    gsb_host_model gsb_host_model_inst (.clk(clk), .rd_en(rd_en), .wr_en(wr_en),
        .addr(addr), .wdata(wdata), .rdata(rdata));

    // A hung run is cut short well above the several hundred cycles needed.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // =========================================================
    // Shared checks
    task automatic check_word(input string what, input logic [15:0] exp,
                              input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_ctrl(input gsb_ctrl_s exp, input gsb_ctrl_s seen);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD ctrl expected %h seen %h", exp, seen);
        end
    endtask

    // Control outputs mirror bypass bits 15:9 and 7:1 in order.
    function automatic gsb_ctrl_s ctrl_of(input logic [15:0] b);
        return gsb_ctrl_s'({b[15:9], b[7:1]});
    endfunction

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string what);
        gsb_host_model_inst.rd(a, got);
        check_word(what, exp, got);
    endtask

    task automatic pulse_cnt(input int n, input logic fc);
        repeat (n) begin
            @(negedge clk);
            rx_evt = ~fc;
            fc_evt = fc;
            @(negedge clk);
            rx_evt = 1'b0;
            fc_evt = 1'b0;
        end
    endtask

    task automatic pulse_soft(input logic en);
        @(negedge clk);
        sticky_en = en;
        soft_rst = 1'b1;
        @(negedge clk);
        soft_rst = 1'b0;
    endtask

    // =========================================================
    // Scenarios
    // Defaults after reset: bypass has bits 7 and 3 set, all else clear.
    task automatic test_reset_values();
        rd_chk(5'h11, 16'h0000, "status reset");
        rd_chk(5'h12, 16'h0088, "bypass reset");
        check_ctrl(ctrl_of(16'h0088), ctrl);
        rd_chk(5'h13, 16'h0000, "rx count reset");
        rd_chk(5'h14, 16'h0000, "fc count reset");
    endtask

    // Live levels land in bits 15, 12, 6 and 5; detect-disable masks bit 6.
    task automatic test_levels();
        @(negedge clk);
        levels = '1;
        repeat (2) @(negedge clk);
        rd_chk(5'h11, 16'h9060, "status levels");
        gsb_host_model_inst.wr(5'h12, 16'h0040);
        repeat (2) @(negedge clk);
        rd_chk(5'h11, 16'h9020, "noncompliant masked");
        levels = '0;
        repeat (2) @(negedge clk);
    endtask

    // Every writable bit set, then every bit cleared; reserved bits stay 0.
    task automatic test_bypass_rw();
        gsb_host_model_inst.wr(5'h12, 16'hffff);
        check_ctrl(ctrl_of(16'hfefe), ctrl);
        rd_chk(5'h12, 16'hfefe, "bypass ones");
        gsb_host_model_inst.wr(5'h12, 16'h0000);
        check_ctrl(ctrl_of(16'h0000), ctrl);
        rd_chk(5'h12, 16'h0000, "bypass zeros");
        gsb_host_model_inst.wr(5'h11, 16'hffff);
        gsb_host_model_inst.wr(5'h13, 16'hffff);
        rd_chk(5'h11, 16'h0000, "status write");
        rd_chk(5'h13, 16'h0000, "counter write");
        rd_chk(5'h1f, 16'h0000, "unmapped read");
    endtask

    // Each event latches its own flag, which the next read clears.
    task automatic test_status_flags();
        for (int i = 0; i < 7; i++) begin
            @(negedge clk);
            events = gsb_events_s'(7'(1 << i));
            @(negedge clk);
            events = '0;
            rd_chk(5'h11, 16'(1 << ev_bit[i]), "flag set");
            rd_chk(5'h11, 16'h0000, "flag cleared");
        end
    endtask

    // An event in the same cycle as the clearing read must survive it.
    task automatic test_coincident();
        fork
            rd_chk(5'h11, 16'h0000, "flag before");
            begin
                @(negedge clk);
                events.rx_err = 1'b1;
                @(negedge clk);
                events = '0;
            end
        join
        rd_chk(5'h11, 16'h0800, "flag kept");
        fork
            rd_chk(5'h13, 16'h0000, "count before");
            pulse_cnt(1, 1'b0);
        join
        rd_chk(5'h13, 16'h0001, "count kept");
    endtask

    // Receive errors saturate at 255; false carriers count apart.
    task automatic test_counters();
        pulse_cnt(260, 1'b0);
        pulse_cnt(3, 1'b1);
        rd_chk(5'h13, 16'h00ff, "rx count sat");
        rd_chk(5'h13, 16'h0000, "rx count clr");
        rd_chk(5'h14, 16'h0003, "fc count");
        rd_chk(5'h14, 16'h0000, "fc count clr");
    endtask

    // Sticky bits 7,6,5,4,3,1 survive only with the sticky enable set.
    task automatic test_soft_reset();
        gsb_host_model_inst.wr(5'h12, 16'hffff);
        pulse_soft(1'b1);
        rd_chk(5'h12, 16'h00fa, "sticky kept");
        pulse_soft(1'b0);
        rd_chk(5'h12, 16'h0088, "sticky default");
        check_ctrl(ctrl_of(16'h0088), ctrl);
    endtask

    // =========================================================
    // Verdict
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Reset is held for 20 cycles and the first access waits three more.
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        test_reset_values();
        test_levels();
        test_bypass_rw();
        test_status_flags();
        test_coincident();
        test_counters();
        test_soft_reset();
        report_and_stop();
    end
endmodule
